// ### core/phy_mgmt_pkg.sv
// constants shared by both ends of the serial management link
// assumes a 20 MHz system clock at each end
package phy_mgmt_pkg;
	localparam int CLK_MHZ         = 20;
	localparam int MDC_MAX_MHZ     = 20;
	localparam int MDC_HALF_CYC    = 8;
	localparam int RST_UNAVAIL_US  = 1000;
	localparam int RST_UNAVAIL_CYC = RST_UNAVAIL_US * CLK_MHZ;
	localparam int STRAP_CAP_CYC   = 4;
	localparam int SRST_CYC        = 16;
	localparam int PRE_BITS        = 32;
	localparam int HDR_BITS        = 12;
	localparam int DATA_BITS       = 16;
	localparam int TA_BIT          = 46;
	localparam int DATA_BIT        = 48;
	localparam int LAST_BIT        = 63;
	localparam logic [1:0] OP_RD   = 2'h2;
	localparam logic [1:0] OP_WR   = 2'h1;
	localparam logic [1:0] TA_WR   = 2'h2;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_STAT = 5'h01;
	localparam logic [4:0] REG_ID1  = 5'h02;
	localparam logic [4:0] REG_ID2  = 5'h03;
	localparam logic [4:0] REG_ADV  = 5'h04;
	localparam logic [4:0] REG_PCFG = 5'h10;
	localparam int CB_RST  = 15;
	localparam int CB_SPD  = 13;
	localparam int CB_ANEN = 12;
	localparam int CB_PD   = 11;
	localparam int CB_FDX  = 8;
	localparam int SB_LINK = 2;
	localparam int PB_FIBER = 0;
	localparam logic [15:0] CTRL_WMASK = 16'h7f00;
	localparam logic [15:0] STAT_CAPS  = 16'h7809;
	localparam logic [15:0] ADV_SEL    = 16'h0001;
	localparam logic [15:0] ADV_MASK   = 16'h01e0;
	localparam logic [3:0] ADV_ALL  = 4'hf;
	localparam logic [3:0] ADV_100  = 4'hc;
	localparam logic [3:0] ADV_10   = 4'h3;
	localparam logic [3:0] ADV_HALF = 4'h5;
	localparam logic [1:0] MODE_AN  = 2'h0;
	localparam logic [1:0] MODE_FX  = 2'h1;
	localparam logic [1:0] MODE_100 = 2'h2;
	localparam logic [1:0] MODE_10  = 2'h3;
	// pin vector positions at the device synchroniser
	localparam int P_MDC   = 13;
	localparam int P_MDIO  = 12;
	localparam int P_DIS   = 11;
	localparam int P_HWPD  = 10;
	localparam int P_GPD   = 9;
	localparam int P_HWM   = 8;
	localparam int P_AN    = 7;
	localparam int P_RATE  = 6;
	localparam int P_FDX   = 5;
	localparam int P_FIBER = 4;
	localparam int P_W     = 14;
	// controller command registers
	localparam logic [2:0] HR_ADDR  = 3'h0;
	localparam logic [2:0] HR_WDATA = 3'h1;
	localparam logic [2:0] HR_CMD   = 3'h2;
	localparam logic [2:0] HR_STAT  = 3'h3;
	localparam logic [2:0] HR_RDATA = 3'h4;
	localparam int HC_RD   = 0;
	localparam int HC_WR   = 1;
	localparam int HC_POLL = 2;
endpackage

// ### core/mdio_link_if.sv
// serial management wire between controller and a single port
// assumes a pull-up: the line reads high when nobody drives
`timescale 1ns/1ns
interface mdio_link_if;
	logic mdc;
	logic host_out;
	logic host_oe_n;
	logic dev_out;
	logic dev_oe_n;
	logic mdio;

	assign mdio = !host_oe_n ? host_out : (!dev_oe_n ? dev_out : 1'b1);

	modport dev (input mdc, input mdio, output dev_out, output dev_oe_n);
	modport host (output mdc, output host_out, output host_oe_n,
		input mdio);
endinterface

// ### core/phy_mgmt_dev.sv
// port-side management slave, strap capture, reset and power-down control
// assumes mdc and all pins arrive asynchronously to i_clk
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module phy_mgmt_dev
	import phy_mgmt_pkg::*;
#(
	parameter logic        PORT_NUM     = 1'b0,
	parameter int          RST_WAIT_CYC = RST_UNAVAIL_CYC,
	parameter logic [15:0] ID1_VAL      = 16'h0123,
	parameter logic [15:0] ID2_VAL      = 16'h4567
) (
	input  wire logic       i_clk,
	input  wire logic       i_reset_n,
	mdio_link_if.dev        link,
	input  wire logic       i_mgmt_disable_pin,
	input  wire logic       i_hw_powerdown_pin,
	input  wire logic       i_global_powerdown_pin,
	input  wire logic       i_hw_ctrl_mode,
	input  wire logic       i_autoneg_strap,
	input  wire logic       i_rate_strap,
	input  wire logic       i_fdx_strap,
	input  wire logic       i_fiber_strap,
	input  wire logic [3:0] i_base_addr,
	input  wire logic       i_link_up,
	input  wire logic       i_link_fail,
	output logic            o_mii_en,
	output logic            o_port_run,
	output logic            o_clk_run,
	output logic            o_regs_ready,
	output logic [1:0]      o_mode,
	output logic            o_full_dup,
	output logic            o_an_start
);
	import phy_mgmt_pkg::*;

	typedef enum logic [4:0] {
		S_PRE = 5'b00001,
		S_ST  = 5'b00010,
		S_HDR = 5'b00100,
		S_TA  = 5'b01000,
		S_DAT = 5'b10000
	} dst_e;

	typedef struct packed {
		logic [P_W-1:0] s1;
		logic [P_W-1:0] s2;
		logic [P_W-1:0] s3;
		logic [P_W-1:0] lvl;
		dst_e           st;
		logic [5:0]     pre;
		logic [4:0]     cnt;
		logic [15:0]    sh;
		logic           rd;
		logic [4:0]     ra;
		logic           dout;
		logic           oe_n;
		logic [15:0]    ctrl;
		logic [15:0]    adv;
		logic           fiber;
		logic [15:0]    hw_ctrl;
		logic [15:0]    hw_adv;
		logic           hw_fiber;
		logic           hwmode;
		logic [15:0]    rwait;
		logic           ready;
		logic [4:0]     srst;
		logic           pd_prev;
		logic           lf_prev;
		logic [1:0]     mode;
		logic           fdx;
		logic           an_start;
		logic           mii_en;
		logic           port_run;
		logic           clk_run;
	} dev_s;

	dev_s q;
	dev_s n;

	function automatic logic [15:0] strap_ctrl(input logic an,
		input logic rate, input logic fdx, input logic fib);
		logic [15:0] c;
		c = '0;
		if (fib || !an) begin
			c[CB_SPD] = fib | rate;
			c[CB_FDX] = fdx;
		end else begin
			c[CB_ANEN] = 1'b1;
			c[CB_SPD]  = 1'b1;
			c[CB_FDX]  = 1'b1;
		end
		return c;
	endfunction

	function automatic logic [15:0] strap_adv(input logic rate,
		input logic fdx);
		logic [15:0] a;
		a = ADV_SEL;
		unique case ({rate, fdx})
			2'b11: a[8:5] = ADV_ALL;
			2'b10: a[8:5] = ADV_100;
			2'b01: a[8:5] = ADV_10;
			2'b00: a[8:5] = ADV_HALF;
		endcase
		return a;
	endfunction

	logic [P_W-1:0] pins;
	logic           mdc_rise;
	logic           bitv;
	logic [4:0]     my_addr;
	logic [11:0]    hdr;
	logic [15:0]    wdat;
	logic [15:0]    rval;
	logic           relatch;

	always_comb begin
		pins = {link.mdc, link.mdio, i_mgmt_disable_pin, i_hw_powerdown_pin,
			i_global_powerdown_pin, i_hw_ctrl_mode, i_autoneg_strap,
			i_rate_strap, i_fdx_strap, i_fiber_strap, i_base_addr};
		n = q;
		n.an_start = 1'b0;
		relatch = 1'b0;
		n.s1 = pins;
		n.s2 = q.s1;
		n.s3 = q.s2;
		// a pin counts only once the later two stages agree
		n.lvl = ((q.s2 ~^ q.s3) & q.s2) | ((q.s2 ^ q.s3) & q.lvl);
		mdc_rise = q.s2[P_MDC] & q.s3[P_MDC] & !q.lvl[P_MDC];
		bitv = q.lvl[P_MDIO];
		my_addr = {q.lvl[3:0], 1'b0} + {4'h0, PORT_NUM};
		hdr = {q.sh[10:0], bitv};
		wdat = {q.sh[14:0], bitv};
		unique case (hdr[4:0])
			REG_CTRL: rval = q.ctrl;
			REG_STAT: rval = STAT_CAPS | (16'(i_link_up) << SB_LINK);
			REG_ID1:  rval = ID1_VAL;
			REG_ID2:  rval = ID2_VAL;
			REG_ADV:  rval = q.adv;
			REG_PCFG: rval = 16'(q.fiber) << PB_FIBER;
			default:  rval = '0;
		endcase
		if (q.lvl[P_GPD]) begin
			// registers frozen; only the synchronisers keep running
			n.clk_run  = 1'b0;
			n.port_run = 1'b0;
			n.oe_n     = 1'b1;
			n.st       = S_PRE;
		end else begin
			if (!q.ready) begin
				n.rwait = q.rwait + 16'h1;
				if (q.rwait == 16'(STRAP_CAP_CYC)) begin
					n.hw_ctrl  = strap_ctrl(q.lvl[P_AN], q.lvl[P_RATE],
						q.lvl[P_FDX], q.lvl[P_FIBER]);
					n.hw_adv   = strap_adv(q.lvl[P_RATE], q.lvl[P_FDX]);
					n.hw_fiber = q.lvl[P_FIBER];
					n.hwmode   = q.lvl[P_HWM];
					n.ctrl     = n.hw_ctrl;
					n.adv      = n.hw_adv;
					n.fiber    = n.hw_fiber;
				end
				if (q.rwait == 16'(RST_WAIT_CYC - 1)) begin
					n.ready = 1'b1;
					relatch = 1'b1;
				end
			end
			n.pd_prev = q.lvl[P_HWPD];
			if (q.pd_prev && !q.lvl[P_HWPD]) begin
				n.ctrl  = q.hw_ctrl;
				n.adv   = q.hw_adv;
				n.fiber = q.hw_fiber;
				relatch = 1'b1;
			end
			n.lf_prev = i_link_fail;
			if (i_link_fail && !q.lf_prev) begin
				relatch = 1'b1;
			end
			if (q.srst != 5'h0) begin
				n.srst = q.srst - 5'h1;
				if (q.srst == 5'h1) begin
					n.ctrl[CB_RST] = 1'b0;
					relatch = 1'b1;
				end
			end
			if (q.lvl[P_DIS] || q.lvl[P_HWPD]) begin
				n.st   = S_PRE;
				n.pre  = '0;
				n.oe_n = 1'b1;
			end else if (mdc_rise) begin
				unique case (q.st)
					S_PRE: begin
						if (bitv) begin
							if (q.pre != 6'(PRE_BITS)) begin
								n.pre = q.pre + 6'h1;
							end
						end else if (q.pre == 6'(PRE_BITS)) begin
							n.st = S_ST;
						end else begin
							n.pre = '0;
						end
					end
					S_ST: begin
						n.pre = '0;
						n.cnt = '0;
						n.st  = bitv ? S_HDR : S_PRE;
					end
					S_HDR: begin
						n.sh  = {4'h0, hdr};
						n.cnt = q.cnt + 5'h1;
						if (q.cnt == 5'(HDR_BITS - 1)) begin
							n.cnt = '0;
							n.st  = S_PRE;
							if (hdr[9:5] == my_addr && q.ready &&
								(hdr[11:10] == OP_RD || hdr[11:10] == OP_WR)) begin
								n.st = S_TA;
								n.rd = (hdr[11:10] == OP_RD);
								n.ra = hdr[4:0];
								// snapshot keeps reads valid during soft reset
								n.sh = rval;
							end
						end
					end
					S_TA: begin
						n.cnt = q.cnt + 5'h1;
						if (q.rd) begin
							n.oe_n = 1'b0;
							n.dout = 1'b0;
							n.cnt  = '0;
							n.st   = S_DAT;
						end else if (q.cnt == 5'h1) begin
							n.cnt = '0;
							n.st  = S_DAT;
						end
					end
					S_DAT: begin
						n.cnt = q.cnt + 5'h1;
						if (q.rd) begin
							if (q.cnt == 5'(DATA_BITS)) begin
								n.oe_n = 1'b1;
								n.st   = S_PRE;
							end else begin
								n.dout = q.sh[15];
								n.sh   = {q.sh[14:0], 1'b0};
							end
						end else begin
							n.sh = wdat;
							if (q.cnt == 5'(DATA_BITS - 1)) begin
								n.st = S_PRE;
								if (!q.hwmode) begin
									unique case (q.ra)
										REG_CTRL: begin
											n.ctrl[14:8] = wdat[14:8];
											// a second reset request mid-reset is dropped
											if (wdat[CB_RST] && q.srst == 5'h0) begin
												n.srst  = 5'(SRST_CYC);
												n.ctrl  = q.hw_ctrl;
												n.ctrl[CB_RST] = 1'b1;
												n.adv   = q.hw_adv;
												n.fiber = q.hw_fiber;
											end
										end
										REG_ADV:  n.adv[8:5] = wdat[8:5];
										REG_PCFG: n.fiber = wdat[PB_FIBER];
										default:  ;
									endcase
								end
							end
						end
					end
					default: begin
						n.st   = S_PRE;
						n.oe_n = 1'b1;
					end
				endcase
			end
			if (relatch) begin
				n.fdx = n.ctrl[CB_FDX];
				if (n.fiber) begin
					n.mode = MODE_FX;
				end else if (n.ctrl[CB_ANEN]) begin
					n.mode     = MODE_AN;
					n.an_start = 1'b1;
				end else begin
					n.mode = n.ctrl[CB_SPD] ? MODE_100 : MODE_10;
				end
			end
			n.clk_run  = !q.lvl[P_HWPD];
			n.mii_en   = !q.lvl[P_HWPD];
			n.port_run = q.ready && !q.lvl[P_HWPD] && !n.ctrl[CB_PD] &&
				n.srst == 5'h0;
		end
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q      <= '0;
			q.st   <= S_PRE;
			q.oe_n <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign link.dev_out  = q.dout;
	assign link.dev_oe_n = q.oe_n;
	assign o_mii_en      = q.mii_en;
	assign o_port_run    = q.port_run;
	assign o_clk_run     = q.clk_run;
	assign o_regs_ready  = q.ready;
	assign o_mode        = q.mode;
	assign o_full_dup    = q.fdx;
	assign o_an_start    = q.an_start;
endmodule

// ### core/phy_mgmt_host.sv
// station management controller: frames reads and writes on the link
// assumes software on a plain strobe port; mdio arrives asynchronously
`timescale 1ns/1ns
module phy_mgmt_host
	import phy_mgmt_pkg::*;
#(
	parameter int RST_WAIT_CYC = RST_UNAVAIL_CYC
) (
	input  wire logic        i_clk,
	input  wire logic        i_reset_n,
	mdio_link_if.host        link,
	input  wire logic [2:0]  i_addr,
	input  wire logic [15:0] i_wdata,
	input  wire logic        i_wr,
	input  wire logic        i_rd,
	output logic [15:0]      o_rdata
);
	import phy_mgmt_pkg::*;

	typedef enum logic [2:0] {
		H_WAIT = 3'b001,
		H_IDLE = 3'b010,
		H_RUN  = 3'b100
	} hst_e;

	typedef struct packed {
		logic [2:0]  sy;
		logic        lvl;
		hst_e        st;
		logic [15:0] rwait;
		logic [2:0]  div;
		logic [5:0]  bitn;
		logic [63:0] sh;
		logic        rd;
		logic        poll;
		logic [15:0] rdat;
		logic [9:0]  adr;
		logic [15:0] wd;
		logic        done;
		logic        mdc;
		logic        out;
		logic        oe_n;
		logic [15:0] rdata;
	} hst_s;

	hst_s q;
	hst_s n;

	function automatic logic [63:0] frame(input logic rd,
		input logic [9:0] adr, input logic [15:0] wd);
		return {{PRE_BITS{1'b1}}, 2'b01, rd ? OP_RD : OP_WR, adr,
			rd ? 2'b11 : TA_WR, rd ? 16'hffff : wd};
	endfunction

	always_comb begin
		n = q;
		n.sy = {q.sy[1:0], link.mdio};
		if (q.sy[1] == q.sy[2]) begin
			n.lvl = q.sy[2];
		end
		if (i_rd) begin
			unique case (i_addr)
				HR_ADDR:  n.rdata = {6'h0, q.adr};
				HR_WDATA: n.rdata = q.wd;
				HR_STAT:  n.rdata = {13'h0, q.done, q.st != H_WAIT,
					q.st == H_RUN};
				HR_RDATA: n.rdata = q.rdat;
				default:  n.rdata = '0;
			endcase
			if (i_addr == HR_STAT) begin
				n.done = 1'b0;
			end
		end
		if (i_wr && i_addr == HR_ADDR) begin
			n.adr = i_wdata[9:0];
		end
		if (i_wr && i_addr == HR_WDATA) begin
			n.wd = i_wdata;
		end
		unique case (q.st)
			H_WAIT: begin
				// register contents not trusted until the wait ends
				n.rwait = q.rwait + 16'h1;
				if (q.rwait == 16'(RST_WAIT_CYC - 1)) begin
					n.st = H_IDLE;
				end
			end
			H_IDLE: begin
				if (i_wr && i_addr == HR_CMD &&
					(i_wdata[HC_RD] || i_wdata[HC_WR])) begin
					n.rd   = i_wdata[HC_RD];
					n.poll = i_wdata[HC_RD] & i_wdata[HC_POLL];
					n.sh   = frame(n.rd, q.adr, q.wd);
					n.out  = 1'b1;
					n.oe_n = 1'b0;
					n.bitn = '0;
					n.div  = '0;
					n.mdc  = 1'b0;
					n.st   = H_RUN;
				end
			end
			H_RUN: begin
				n.div = q.div + 3'h1;
				// half period of 8 cycles keeps mdc near 1.25 MHz
				if (q.div == 3'(MDC_HALF_CYC - 1)) begin
					n.div = '0;
					if (!q.mdc) begin
						n.mdc = 1'b1;
						if (q.rd && q.bitn >= 6'(DATA_BIT)) begin
							n.rdat = {q.rdat[14:0], q.lvl};
						end
					end else begin
						n.mdc = 1'b0;
						if (q.bitn == 6'(LAST_BIT)) begin
							n.oe_n = 1'b1;
							n.out  = 1'b1;
							if (q.poll && q.rdat[CB_RST]) begin
								n.sh   = frame(1'b1, q.adr, q.wd);
								n.oe_n = 1'b0;
								n.bitn = '0;
							end else begin
								n.done = 1'b1;
								n.st   = H_IDLE;
							end
						end else begin
							n.bitn = q.bitn + 6'h1;
							n.sh   = {q.sh[62:0], 1'b1};
							n.out  = q.sh[62];
							n.oe_n = q.rd && q.bitn >= 6'(TA_BIT - 1);
						end
					end
				end
			end
			default: n.st = H_IDLE;
		endcase
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q      <= '0;
			q.st   <= H_WAIT;
			q.oe_n <= 1'b1;
			q.out  <= 1'b1;
		end else begin
			q <= n;
		end
	end

	assign link.mdc       = q.mdc;
	assign link.host_out  = q.out;
	assign link.host_oe_n = q.oe_n;
	assign o_rdata        = q.rdata;
endmodule

// ### tb/phy_mgmt_assertions.sv
// concurrent checks on the serial management wire
// assumes both ends share i_clk and i_reset_n with the bench
`timescale 1ns/1ns
module phy_mgmt_assertions (
	input  wire logic i_clk,
	input  wire logic i_reset_n,
	input  wire logic mdc,
	input  wire logic host_out,
	input  wire logic host_oe_n,
	input  wire logic dev_out,
	input  wire logic dev_oe_n,
	input  wire logic mdio
);
	logic [6:0] bit_cnt_q;
	logic [9:0] drv_cnt_q;
	logic       mdc_q;

	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_reset_n);

	// rises counted only while the controller owns the line
	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			bit_cnt_q <= 7'h00;
			drv_cnt_q <= 10'h000;
			mdc_q     <= 1'b0;
		end else begin
			mdc_q     <= mdc;
			bit_cnt_q <= host_oe_n ? 7'h00 : bit_cnt_q + 7'(mdc && !mdc_q);
			drv_cnt_q <= dev_oe_n ? 10'h000 : drv_cnt_q + 10'h001;
		end
	end

	sequence s_rise_at(int n);
		$rose(mdc) && !host_oe_n && bit_cnt_q == n;
	endsequence
	sequence s_dev_start;
		$fell(dev_oe_n);
	endsequence

	chk_mdc_half: assert property ($changed(mdc) |=> $stable(mdc) [*7])
		else $error("mdc half period under eight clocks");
	chk_no_contention: assert property (!host_oe_n |-> dev_oe_n)
		else $error("both ends drive the line");
	chk_host_released: assert property (s_dev_start |-> host_oe_n)
		else $error("port drives before controller release");
	chk_preamble_ones: assert property (
		$rose(mdc) && !host_oe_n && bit_cnt_q < 32 |-> host_out)
		else $error("preamble bit not one");
	chk_start_zero: assert property (s_rise_at(32) |-> !mdio)
		else $error("first start bit not zero");
	chk_start_one: assert property (s_rise_at(33) |-> mdio)
		else $error("second start bit not one");
	chk_frame_len: assert property ($rose(host_oe_n)
		|-> bit_cnt_q == 46 || bit_cnt_q == 64)
		else $error("controller drove wrong bit count");
	chk_ta_zero: assert property (
		$rose(mdc) && !dev_oe_n && drv_cnt_q < 16 |-> !mdio && !dev_out)
		else $error("turnaround bit from port not zero");
	chk_dev_drive_len: assert property ($rose(dev_oe_n)
		|-> drv_cnt_q >= 240 && drv_cnt_q <= 300)
		else $error("port drive span not seventeen bits");
endmodule

// ### tb/phy_mgmt_config_control_tb_top.sv
// self-checking bench: controller and one port joined over the wire
// assumes the shortened ready wait of 100 cycles at both ends
`timescale 1ns/1ns
module phy_mgmt_config_control_tb_top;
	import phy_mgmt_pkg::*;
	localparam int          WAIT_CYC = 100;
	localparam logic [15:0] ID1_TB   = 16'h1a2b; // arbitrary
	localparam logic [15:0] ID2_TB   = 16'h3c4d; // arbitrary
	localparam logic [4:0]  PHY      = 5'h0b; // base 5, port 1
	logic        i_clk, i_reset_n, mgmt_disable_pin, hw_powerdown_pin;
	logic        global_pd_pin, hw_mode, autoneg_strap, rate_strap;
	logic        fdx_strap, fiber_strap, link_up, link_fail, hwr, hrd;
	logic [3:0]  base_addr;
	logic [2:0]  haddr;
	logic [15:0] hwdata, hrdata;
	logic        mii_en, port_run, clk_run, regs_ready, full_dup;
	logic        an_start;
	int          an_pulses = 0;
	logic [1:0]  mode;
	logic [4:0]  phy_sel;
	int          failures, cmp_count;

	mdio_link_if mdio_link_if_inst ();
	phy_mgmt_dev #(.PORT_NUM(1'b1), .RST_WAIT_CYC(WAIT_CYC),
		.ID1_VAL(ID1_TB), .ID2_VAL(ID2_TB)) phy_mgmt_dev_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .link(mdio_link_if_inst),
		.i_mgmt_disable_pin(mgmt_disable_pin),
		.i_hw_powerdown_pin(hw_powerdown_pin),
		.i_global_powerdown_pin(global_pd_pin), .i_hw_ctrl_mode(hw_mode),
		.i_autoneg_strap(autoneg_strap), .i_rate_strap(rate_strap),
		.i_fdx_strap(fdx_strap), .i_fiber_strap(fiber_strap),
		.i_base_addr(base_addr), .i_link_up(link_up),
		.i_link_fail(link_fail), .o_mii_en(mii_en), .o_port_run(port_run),
		.o_clk_run(clk_run), .o_regs_ready(regs_ready), .o_mode(mode),
		.o_full_dup(full_dup), .o_an_start(an_start));
	phy_mgmt_host #(.RST_WAIT_CYC(WAIT_CYC)) phy_mgmt_host_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n), .link(mdio_link_if_inst),
		.i_addr(haddr), .i_wdata(hwdata), .i_wr(hwr), .i_rd(hrd),
		.o_rdata(hrdata));
	phy_mgmt_assertions phy_mgmt_assertions_inst (
		.i_clk(i_clk), .i_reset_n(i_reset_n),
		.mdc(mdio_link_if_inst.mdc), .host_out(mdio_link_if_inst.host_out),
		.host_oe_n(mdio_link_if_inst.host_oe_n),
		.dev_out(mdio_link_if_inst.dev_out),
		.dev_oe_n(mdio_link_if_inst.dev_oe_n), .mdio(mdio_link_if_inst.mdio));

	// never gated: this one clock stands in for the reference
	initial begin
		i_clk = 1'b0;
		forever #25 i_clk = ~i_clk;
	end
	// the start pulse stands one cycle only, so count it as it passes
	always @(posedge i_clk) begin
		if (an_start === 1'b1) begin
			an_pulses++;
		end
	end

	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("mismatch at %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		if (failures == 0 && cmp_count > 0) begin
			$display("== PASSED ==");
		end else begin
			$display("== FAILED ==");
		end
		$finish;
	endtask
	task automatic settle();
		repeat (8) @(posedge i_clk);
	endtask
	task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge i_clk);
		haddr <= a;
		hwdata <= d;
		hwr <= 1'b1;
		@(posedge i_clk);
		hwr <= 1'b0;
	endtask
	task automatic reg_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge i_clk);
		haddr <= a;
		hrd <= 1'b1;
		@(posedge i_clk);
		hrd <= 1'b0;
		@(negedge i_clk);
		d = hrdata;
	endtask
	// one whole frame; done is sticky, so polling cannot miss it
	task automatic frame(input logic [4:0] ra, input logic [15:0] wd,
		input logic is_wr, output logic [15:0] d);
		int n;
		logic [15:0] cmd;
		reg_wr(HR_ADDR, {6'h00, phy_sel, ra});
		reg_wr(HR_WDATA, wd);
		// reads of control poll until the soft-reset bit clears
		cmd = is_wr ? 16'h0002 : (ra == REG_CTRL ? 16'h0005 : 16'h0001);
		reg_wr(HR_CMD, cmd);
		d = 16'h0000;
		for (n = 0; n < 2000 && d[2] !== 1'b1; n++) reg_rd(HR_STAT, d);
		check({15'h0000, d[2]}, 16'h0001);
		reg_rd(HR_RDATA, d);
	endtask
	task automatic wait_ready();
		logic [15:0] d;
		int n;
		d = 16'h0000;
		for (n = 0; n < 500 && !(d[1] === 1'b1 && regs_ready === 1'b1); n++)
			reg_rd(HR_STAT, d);
		check({15'h0000, regs_ready}, 16'h0001);
	endtask

	task automatic t_straps_ident();
		logic [15:0] d;
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h3100);
		frame(REG_ADV, 16'h0000, 1'b0, d);
		check(d & ADV_MASK, ADV_MASK);
		check({14'h0000, mode}, {14'h0000, MODE_AN});
		frame(REG_ID1, 16'h0000, 1'b0, d);
		check(d, ID1_TB);
		frame(REG_ID2, 16'h0000, 1'b0, d);
		check(d, ID2_TB);
		reg_rd(3'h7, d);
		check(d, 16'h0000);
	endtask
	task automatic t_addr_disable();
		logic [15:0] d;
		phy_sel = 5'h0a;
		frame(REG_ID1, 16'h0000, 1'b0, d);
		check(d, 16'hffff);
		phy_sel = PHY;
		@(posedge i_clk);
		mgmt_disable_pin <= 1'b1;
		frame(REG_CTRL, 16'h2100, 1'b1, d);
		frame(REG_ID1, 16'h0000, 1'b0, d);
		check(d, 16'hffff);
		@(posedge i_clk);
		mgmt_disable_pin <= 1'b0;
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h3100);
	endtask
	task automatic t_forced_pd_srst();
		logic [15:0] d;
		int p;
		frame(REG_CTRL, 16'h2100, 1'b1, d);
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h2100);
		@(posedge i_clk);
		link_fail <= 1'b1;
		@(posedge i_clk);
		link_fail <= 1'b0;
		settle();
		check({14'h0000, mode}, {14'h0000, MODE_100});
		check({15'h0000, full_dup}, 16'h0001);
		frame(REG_CTRL, 16'h2900, 1'b1, d);
		settle();
		check({14'h0000, port_run, clk_run}, 16'h0001);
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h2900);
		frame(REG_PCFG, 16'h0001, 1'b1, d);
		frame(REG_PCFG, 16'h0000, 1'b0, d);
		check(d, 16'h0001);
		@(posedge i_clk);
		link_fail <= 1'b1;
		@(posedge i_clk);
		link_fail <= 1'b0;
		settle();
		check({14'h0000, mode}, {14'h0000, MODE_FX});
		// pins moved after the hardware reset must not be seen again
		@(posedge i_clk);
		autoneg_strap <= 1'b0;
		p = an_pulses;
		frame(REG_CTRL, 16'h8000, 1'b1, d);
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check({d[15], 15'h0000}, 16'h0000);
		check(d & CTRL_WMASK, 16'h3100);
		check({14'h0000, mode}, {14'h0000, MODE_AN});
		check(16'(an_pulses - p), 16'h0001);
		frame(REG_PCFG, 16'h0000, 1'b0, d);
		check(d, 16'h0000);
	endtask
	task automatic t_power_down();
		logic [15:0] d;
		frame(REG_CTRL, 16'h2100, 1'b1, d);
		@(posedge i_clk);
		hw_powerdown_pin <= 1'b1;
		settle();
		check({15'h0000, port_run}, 16'h0000);
		frame(REG_ID1, 16'h0000, 1'b0, d);
		check(d, 16'hffff);
		@(posedge i_clk);
		hw_powerdown_pin <= 1'b0;
		settle();
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h3100);
		@(posedge i_clk);
		global_pd_pin <= 1'b1;
		settle();
		check({14'h0000, port_run, clk_run}, 16'h0000);
		@(posedge i_clk);
		global_pd_pin <= 1'b0;
		settle();
		frame(REG_ID1, 16'h0000, 1'b0, d);
		check(d, ID1_TB);
	endtask
	// second reset, now in hardware mode with forced 10 full duplex
	task automatic t_hw_mode();
		logic [15:0] d;
		@(posedge i_clk);
		i_reset_n <= 1'b0;
		hw_mode <= 1'b1;
		autoneg_strap <= 1'b0;
		rate_strap <= 1'b0;
		settle();
		check({15'h0000, mii_en}, 16'h0000);
		@(posedge i_clk);
		i_reset_n <= 1'b1;
		settle();
		check({15'h0000, regs_ready}, 16'h0000);
		check({15'h0000, mii_en}, 16'h0001);
		wait_ready();
		frame(REG_CTRL, 16'h3100, 1'b1, d);
		frame(REG_CTRL, 16'h0000, 1'b0, d);
		check(d & CTRL_WMASK, 16'h0100);
		check({14'h0000, mode}, {14'h0000, MODE_10});
		check({15'h0000, full_dup}, 16'h0001);
	endtask

	initial begin
		failures = 0;
		cmp_count = 0;
		i_reset_n = 1'b0;
		{mgmt_disable_pin, hw_powerdown_pin, global_pd_pin, hw_mode} = 4'h0;
		{autoneg_strap, rate_strap, fdx_strap, fiber_strap} = 4'he;
		{link_up, link_fail, hwr, hrd} = 4'h8;
		base_addr = 4'h5;
		haddr = 3'h0;
		hwdata = 16'h0000;
		phy_sel = PHY;
		repeat (3) @(posedge i_clk);
		i_reset_n <= 1'b1;
		wait_ready();
		t_straps_ident();
		t_addr_disable();
		t_forced_pd_srst();
		t_power_down();
		t_hw_mode();
		test_done();
	end
	// about 24k cycles of traffic expected; cut off at 90k, nearly four times that
	initial begin
		#(90000 * 50);
		failures++;
		test_done();
	end
endmodule
